// File: hw/hpa_pkg.sv
// constants, field positions and state types of the max address command unit
// assumes a 32-bit ahb-lite slave port with one register per aligned word
package hpa_pkg;
	localparam int          ADDR_W            = 8;
	localparam int          LBA_W             = 28;
	localparam int          WORD_W            = 16;
	localparam int          SECTOR_WORDS      = 256;
	localparam int          PW_FIRST_WORD     = 1;
	localparam int          PW_WORDS          = 16;
	// register byte offsets
	localparam logic [7:0]  OFS_FEATURES      = 8'h00;
	localparam logic [7:0]  OFS_SECCNT        = 8'h04;
	localparam logic [7:0]  OFS_LBA_BYTE_LOW       = 8'h08;
	localparam logic [7:0]  OFS_LBA_BYTE_MIDDLE       = 8'h0c;
	localparam logic [7:0]  OFS_LBA_BYTE_HIGH      = 8'h10;
	localparam logic [7:0]  OFS_DEVICE        = 8'h14;
	localparam logic [7:0]  OFS_COMMAND       = 8'h18;
	localparam logic [7:0]  OFS_STATUS        = 8'h1c;
	localparam logic [7:0]  OFS_ERROR         = 8'h20;
	localparam logic [7:0]  OFS_DATA          = 8'h24;
	localparam logic [7:0]  OFS_CONFIG        = 8'h28;
	localparam logic [7:0]  OFS_CONTROL       = 8'h2c;
	localparam logic [7:0]  OFS_CHECK_LBA     = 8'h30;
	localparam logic [7:0]  OFS_CHECK_RESULT  = 8'h34;
	localparam logic [7:0]  OFS_IDENT_60      = 8'h38;
	localparam logic [7:0]  OFS_IDENT_100     = 8'h3c;
	localparam logic [7:0]  OFS_HPA_STATE     = 8'h40;
	// opcodes and selectors
	localparam logic [7:0]  OP_SET_MAX        = 8'hf9;
	localparam logic [7:0]  OP_READ_NATIVE    = 8'hf8;
	localparam logic [7:0]  SEL_PASSWORD      = 8'h01;
	localparam logic [7:0]  SEL_LOCK          = 8'h02;
	localparam logic [7:0]  SEL_UNLOCK        = 8'h03;
	localparam logic [7:0]  SEL_FREEZE        = 8'h04;
	// field positions
	localparam int          ST_BSY            = 7;
	localparam int          ST_DRDY           = 6;
	localparam int          ST_DF             = 5;
	localparam int          ST_DRQ            = 3;
	localparam int          ST_ERR            = 0;
	localparam int          ER_IDNF           = 4;
	localparam int          ER_ABRT           = 2;
	localparam int          DEV_LBA_BIT       = 6;
	localparam int          VOL_BIT           = 0;
	localparam int          CFG_SUPPORTED     = 0;
	localparam int          CFG_EXT_AREA      = 1;
	localparam int          CFG_LBA48         = 2;
	localparam int          CTL_HARD_RESET    = 0;
	localparam logic [2:0]  CFG_RESET         = 3'h5;
	localparam logic [7:0]  STATUS_RESET      = 8'h40;
	typedef enum logic [1:0] {HPA_UNLOCKED, HPA_LOCKED, HPA_FROZEN} hpa_state_t;
endpackage

// File: hw/max_address_command_unit.sv
// task-file command unit for max address, password, lock and freeze handling
// assumes an ahb-lite master doing single word transfers; sys_rst_i is power-on
`timescale 1ns/100ps
module max_address_command_unit import hpa_pkg::*; #(
	parameter logic [LBA_W-1:0] NATIVE_MAX_LBA = 28'hfffffff
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	// ahb-lite slave
	input  wire logic         hsel_i,
	input  wire logic [31:0]  haddr_i,
	input  wire logic [1:0]   htrans_i,
	input  wire logic         hwrite_i,
	input  wire logic [2:0]   hsize_i,
	input  wire logic [31:0]  hwdata_i,
	input  wire logic         hready_i,
	output logic [31:0]       hrdata_o,
	output logic              hreadyout_o,
	output logic              hresp_o
);
	// bus front end
	logic              wr_pend;
	logic              rd_pend;
	logic [ADDR_W-1:0] dp_addr;
	wire logic         accept = hsel_i & htrans_i[1] & hready_i & ~rd_pend;
	wire logic [31:0]  rd_mux;

	// reads take one wait state so a write just before is visible, except the sector completion, which lands a cycle after the last data word
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_pend     <= 1'b0;
			rd_pend     <= 1'b0;
			dp_addr     <= '0;
			hrdata_o    <= '0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else if (rd_pend) begin
			hrdata_o    <= rd_mux;
			hreadyout_o <= 1'b1;
			rd_pend     <= 1'b0;
			wr_pend     <= 1'b0;
		end else begin
			wr_pend     <= accept & hwrite_i;
			rd_pend     <= accept & ~hwrite_i;
			hreadyout_o <= ~(accept & ~hwrite_i);
			if (accept) begin
				dp_addr <= haddr_i[ADDR_W-1:0];
			end
		end
	end

	// write decode
	wire logic wr_feat   = wr_pend & (dp_addr == OFS_FEATURES);
	wire logic wr_sc     = wr_pend & (dp_addr == OFS_SECCNT);
	wire logic wr_lo     = wr_pend & (dp_addr == OFS_LBA_BYTE_LOW);
	wire logic wr_mid    = wr_pend & (dp_addr == OFS_LBA_BYTE_MIDDLE);
	wire logic wr_hi     = wr_pend & (dp_addr == OFS_LBA_BYTE_HIGH);
	wire logic wr_dev    = wr_pend & (dp_addr == OFS_DEVICE);
	wire logic wr_cmd    = wr_pend & (dp_addr == OFS_COMMAND);
	wire logic wr_data   = wr_pend & (dp_addr == OFS_DATA);
	wire logic wr_cfg    = wr_pend & (dp_addr == OFS_CONFIG);
	wire logic wr_ctl    = wr_pend & (dp_addr == OFS_CONTROL);
	wire logic wr_chk    = wr_pend & (dp_addr == OFS_CHECK_LBA);
	wire logic hard_rst  = wr_ctl & hwdata_i[CTL_HARD_RESET];

	// task file and device state
	logic [7:0]       features;
	logic [7:0]       seccnt;
	logic [7:0]       lba_lo;
	logic [7:0]       lba_byte_middle;
	logic [7:0]       lba_hi;
	logic [7:0]       devreg;
	logic [7:0]       status;
	logic [7:0]       errreg;
	logic [2:0]       cfg;
	logic             native_hist;
	logic             nv_used;
	logic [LBA_W-1:0] cur_max;
	logic [LBA_W-1:0] nv_max;
	logic [31:0]      ident_max;
	hpa_state_t       hpa_state;
	logic             pw_set;
	logic             xfer_unlock;
	logic             chk_reject;
	logic [PW_WORDS*WORD_W-1:0] pw_store;
	logic [PW_WORDS*WORD_W-1:0] pw_rx;
	logic             sink_done;

	wire logic supported = cfg[CFG_SUPPORTED];
	wire logic drq       = status[ST_DRQ];
	wire logic cmd_go    = wr_cmd & ~drq;
	wire logic [7:0] op  = hwdata_i[7:0];
	wire logic [LBA_W-1:0] req_lba = {devreg[3:0], lba_hi, lba_byte_middle, lba_lo};

	// command decode
	wire logic f9        = cmd_go & (op == OP_SET_MAX);
	wire logic do_rnma   = cmd_go & (op == OP_READ_NATIVE);
	wire logic do_setmax = f9 & native_hist;
	wire logic plain_f9  = f9 & ~native_hist;
	wire logic do_pw     = plain_f9 & (features == SEL_PASSWORD);
	wire logic do_lock   = plain_f9 & (features == SEL_LOCK);
	wire logic do_unlock = plain_f9 & (features == SEL_UNLOCK);
	wire logic do_frz    = plain_f9 & (features == SEL_FREEZE);
	wire logic do_other  = plain_f9 & ~(do_pw | do_lock | do_unlock | do_frz);
	wire logic do_unknown = cmd_go & ~f9 & ~do_rnma;

	// abort conditions
	wire logic sm_abort  = ~supported | (req_lba > NATIVE_MAX_LBA) | cfg[CFG_EXT_AREA]
	                       | (hpa_state != HPA_UNLOCKED) | ~devreg[DEV_LBA_BIT];
	wire logic sm_idnf   = seccnt[VOL_BIT] & nv_used;
	wire logic sm_ok     = do_setmax & ~sm_abort & ~sm_idnf;
	wire logic pw_abort  = ~supported | (hpa_state != HPA_UNLOCKED);
	wire logic lk_abort  = ~supported | (hpa_state == HPA_FROZEN) | ~pw_set;
	wire logic ul_abort  = ~supported | (hpa_state != HPA_LOCKED);
	wire logic fz_abort  = ~supported | (hpa_state == HPA_FROZEN) | ~pw_set;

	wire logic imm_abort = (do_setmax & sm_abort) | (do_pw & pw_abort)
	                       | (do_lock & lk_abort) | (do_unlock & ul_abort)
	                       | (do_frz & fz_abort) | do_other | do_unknown;
	wire logic imm_idnf  = do_setmax & sm_idnf;
	wire logic xfer_go   = (do_pw & ~pw_abort) | (do_unlock & ~ul_abort);
	wire logic pw_match  = (pw_rx == pw_store);
	wire logic end_abort = sink_done & xfer_unlock & ~pw_match;
	wire logic cmd_done  = (cmd_go & ~xfer_go) | sink_done;
	// error bits are placed by their named positions so the map lives in one place
	wire logic [7:0] idnf_bit = 8'(imm_idnf) << ER_IDNF;
	wire logic [7:0] abrt_bit = 8'(imm_abort | end_abort) << ER_ABRT;
	wire logic [7:0] next_err = idnf_bit | abrt_bit;

	// host writes to the task file; completion returns lba fields afterwards
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			features <= '0;
			seccnt   <= '0;
			lba_lo   <= '0;
			lba_byte_middle  <= '0;
			lba_hi   <= '0;
			devreg   <= '0;
		end else if (sm_ok) begin
			{devreg[3:0], lba_hi, lba_byte_middle, lba_lo} <= req_lba;
		end else if (do_rnma & supported) begin
			{devreg[3:0], lba_hi, lba_byte_middle, lba_lo} <= NATIVE_MAX_LBA;
		end else begin
			if (wr_feat) features <= hwdata_i[7:0];
			if (wr_sc)   seccnt   <= hwdata_i[7:0];
			if (wr_lo)   lba_lo   <= hwdata_i[7:0];
			if (wr_mid)  lba_byte_middle  <= hwdata_i[7:0];
			if (wr_hi)   lba_hi   <= hwdata_i[7:0];
			if (wr_dev)  devreg   <= hwdata_i[7:0];
		end
	end

	// status and error on completion
	always_ff @(posedge clk_i) begin
		if (sys_rst_i | hard_rst) begin
			status <= STATUS_RESET;
			errreg <= '0;
		end else if (xfer_go) begin
			status <= '0;
			status[ST_DRDY] <= 1'b1;
			status[ST_DRQ]  <= 1'b1;
			errreg <= '0;
		end else if (cmd_done) begin
			status <= '0;
			status[ST_DRDY] <= 1'b1;
			status[ST_ERR]  <= |next_err;
			errreg <= next_err;
		end
	end

	// history flag lasts exactly one command
	always_ff @(posedge clk_i) begin
		if (sys_rst_i | hard_rst) begin
			native_hist <= 1'b0;
		end else if (cmd_go) begin
			native_hist <= do_rnma & supported;
		end
	end

	// max address, its non-volatile copy and identify image
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cur_max   <= NATIVE_MAX_LBA;
			nv_max    <= NATIVE_MAX_LBA;
			ident_max <= 32'(NATIVE_MAX_LBA) + 32'h1;
			nv_used   <= 1'b0;
		end else if (hard_rst) begin
			cur_max   <= nv_max;
			ident_max <= 32'(nv_max) + 32'h1;
			nv_used   <= 1'b0;
		end else if (sm_ok) begin
			cur_max   <= req_lba;
			ident_max <= 32'(req_lba) + 32'h1;
			if (seccnt[VOL_BIT]) begin
				nv_max  <= req_lba;
				nv_used <= 1'b1;
			end
		end
	end

	// lock states; the unlock retry counter is not modelled
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			hpa_state   <= HPA_UNLOCKED;
			pw_set      <= 1'b0;
			pw_store    <= '0;
			xfer_unlock <= 1'b0;
		end else begin
			if (xfer_go) begin
				xfer_unlock <= do_unlock;
			end
			if (do_lock & ~lk_abort) begin
				hpa_state <= HPA_LOCKED;
			end
			if (do_frz & ~fz_abort) begin
				hpa_state <= HPA_FROZEN;
			end
			if (sink_done & ~xfer_unlock) begin
				pw_store  <= pw_rx;
				pw_set    <= 1'b1;
				hpa_state <= HPA_UNLOCKED;
			end
			if (sink_done & xfer_unlock & pw_match) begin
				hpa_state <= HPA_UNLOCKED;
			end
		end
	end

	// media access check against the current max
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			chk_reject <= 1'b0;
		end else if (wr_chk) begin
			chk_reject <= (hwdata_i[LBA_W-1:0] > cur_max) | (|hwdata_i[31:LBA_W]);
		end
	end

	// configuration
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg <= CFG_RESET;
		end else if (wr_cfg) begin
			cfg <= hwdata_i[2:0];
		end
	end

	sector_sink #(
		.N_WORDS  (SECTOR_WORDS),
		.PW_FIRST (PW_FIRST_WORD),
		.PW_N     (PW_WORDS)
	) u_sink (
		.clk_i        (clk_i),
		.sys_rst_i    (sys_rst_i | hard_rst),
		.start_i      (xfer_go),
		.word_valid_i (wr_data & drq),
		.word_i       (hwdata_i[WORD_W-1:0]),
		.done_o       (sink_done),
		.password_o   (pw_rx)
	);

	// read selection; unmapped offsets read zero
	wire logic [31:0] ident_100 = cfg[CFG_LBA48] ? ident_max : 32'h0;
	wire logic [31:0] state_word = {27'h0, pw_set, nv_used, native_hist, hpa_state};
	assign rd_mux =
		(dp_addr == OFS_SECCNT)       ? {24'h0, seccnt}   :
		(dp_addr == OFS_LBA_BYTE_LOW)      ? {24'h0, lba_lo}   :
		(dp_addr == OFS_LBA_BYTE_MIDDLE)      ? {24'h0, lba_byte_middle}  :
		(dp_addr == OFS_LBA_BYTE_HIGH)     ? {24'h0, lba_hi}   :
		(dp_addr == OFS_DEVICE)       ? {24'h0, devreg}   :
		(dp_addr == OFS_STATUS)       ? {24'h0, status}   :
		(dp_addr == OFS_ERROR)        ? {24'h0, errreg}   :
		(dp_addr == OFS_CONFIG)       ? {29'h0, cfg}      :
		(dp_addr == OFS_CHECK_RESULT) ? {31'h0, chk_reject} :
		(dp_addr == OFS_IDENT_60)     ? ident_max         :
		(dp_addr == OFS_IDENT_100)    ? ident_100         :
		(dp_addr == OFS_HPA_STATE)    ? state_word        : 32'h0;
endmodule

// File: hw/sector_sink.sv
// collects one sector of data-out words and keeps the password words
// assumes words arrive only while the owner holds its data request
`timescale 1ns/100ps
module sector_sink import hpa_pkg::*; #(
	parameter int N_WORDS  = SECTOR_WORDS,
	parameter int PW_FIRST = PW_FIRST_WORD,
	parameter int PW_N     = PW_WORDS
) (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	// control
	input  wire logic                   start_i,
	input  wire logic                   word_valid_i,
	input  wire logic [WORD_W-1:0]      word_i,
	// result
	output logic                        done_o,
	output logic [PW_N*WORD_W-1:0]      password_o
);
	logic [$clog2(N_WORDS+1)-1:0] count;
	logic                         active;
	wire logic                    last_word = word_valid_i & active
	                                          & (count == ($clog2(N_WORDS+1))'(N_WORDS-1));

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			count  <= '0;
			active <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= last_word;
			if (start_i) begin
				count  <= '0;
				active <= 1'b1;
			end else if (word_valid_i & active) begin
				count  <= count + 1'b1;
				active <= ~last_word;
			end
		end
	end

	// words outside the password field are dropped
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			password_o <= '0;
		end else begin
			for (int i = 0; i < PW_N; i++) begin
				if (word_valid_i & active & (count == ($clog2(N_WORDS+1))'(PW_FIRST + i))) begin
					password_o[i*WORD_W +: WORD_W] <= word_i;
				end
			end
		end
	end
endmodule

// File: sim/max_address_command_unit_bench.sv
// bench: host model calls with expected register values
// assumes a small native capacity; a cycle ceiling cuts hangs short
`timescale 1ns/100ps
module max_address_command_unit_bench import hpa_pkg::*;;
	localparam logic [27:0] NAT = 28'h0001000;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        hsel, hwrite, hready, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  bad [3] = '{8'h00, 8'h05, 8'hff};
	int          err_count = 0;
	int          compares = 0;
	int          cycles = 0;
	initial forever #20 clk_i = ~clk_i;
	task_file_host i_host (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
		.haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
		.hwdata_o(hwdata));
	max_address_command_unit #(.NATIVE_MAX_LBA(NAT)) i_dut (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp));
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		i_host.xfer(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		i_host.xfer(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), q & m, e);
	endtask
	task automatic cmd(input logic [7:0] f, input logic [7:0] op);
		wr(OFS_FEATURES, {24'h0, f});
		wr(OFS_COMMAND, {24'h0, op});
	endtask
	task automatic res(input logic [7:0] st, input logic [7:0] er);
		rc(OFS_ERROR, 32'hff, {24'h0, er});
		rc(OFS_STATUS, 32'hff, {24'h0, st});
	endtask
	task automatic ids(input logic [27:0] m);
		rc(OFS_IDENT_60, 32'hffffffff, {4'h0, m} + 32'h1);
		rc(OFS_IDENT_100, 32'hffffffff, {4'h0, m} + 32'h1);
	endtask
	task automatic barred(input logic [27:0] m);
		i_host.set_max(28'h0000300, 1'b0);
		res(8'h41, 8'h04);
		ids(m);
		cmd(SEL_PASSWORD, OP_SET_MAX);
		res(8'h41, 8'h04);
	endtask
	task automatic end_sim();
		if (err_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		res(8'h40, 8'h00);
		ids(NAT);
		rc(8'h80, 32'hffffffff, 32'h0);
		wr(OFS_STATUS, 32'h0);
		rc(OFS_STATUS, 32'hff, 32'h40);
		foreach (bad[i]) begin
			cmd(bad[i], OP_SET_MAX);
			res(8'h41, 8'h04);
		end
		wr(OFS_COMMAND, {24'h0, OP_READ_NATIVE});
		rc(OFS_HPA_STATE, 32'h4, 32'h4);
		cmd(8'h00, 8'h00);
		cmd(8'h00, OP_SET_MAX);
		res(8'h41, 8'h04);
		i_host.set_max(28'h0000a5c, 1'b0);
		res(8'h40, 8'h00);
		rc(OFS_LBA_BYTE_LOW, 32'hff, 32'h5c);
		rc(OFS_LBA_BYTE_MIDDLE, 32'hff, 32'h0a);
		rc(OFS_DEVICE, 32'h0f, 32'h0);
		ids(28'h0000a5c);
		wr(OFS_CHECK_LBA, 32'ha5c);
		rc(OFS_CHECK_RESULT, 32'h1, 32'h0);
		wr(OFS_CHECK_LBA, 32'ha5d);
		rc(OFS_CHECK_RESULT, 32'h1, 32'h1);
		i_host.set_max(NAT + 28'h1, 1'b0);
		res(8'h41, 8'h04);
		ids(28'h0000a5c);
		i_host.set_max(28'h0000700, 1'b1);
		ids(28'h0000700);
		i_host.set_max(28'h0000600, 1'b1);
		res(8'h41, 8'h10);
		ids(28'h0000700);
		i_host.set_max(28'h0000500, 1'b0);
		wr(OFS_CONTROL, 32'h1);
		ids(28'h0000700);
		i_host.set_max(28'h0000650, 1'b1);
		res(8'h40, 8'h00);
		wr(OFS_CONFIG, 32'h7);
		i_host.set_max(28'h0000300, 1'b0);
		res(8'h41, 8'h04);
		ids(28'h0000650);
		wr(OFS_CONFIG, 32'h1);
		rc(OFS_IDENT_100, 32'hffffffff, 32'h0);
		wr(OFS_CONFIG, 32'h0);
		cmd(SEL_PASSWORD, OP_SET_MAX);
		res(8'h41, 8'h04);
		wr(OFS_CONFIG, 32'h5);
		cmd(SEL_PASSWORD, OP_SET_MAX);
		rc(OFS_STATUS, 32'hff, 32'h48);
		i_host.sector();
		res(8'h40, 8'h00);
		rc(OFS_HPA_STATE, 32'h13, 32'h10);
		cmd(SEL_LOCK, OP_SET_MAX);
		rc(OFS_HPA_STATE, 32'h3, 32'h1);
		barred(28'h0000650);
		cmd(SEL_UNLOCK, OP_SET_MAX);
		i_host.sector();
		rc(OFS_HPA_STATE, 32'h3, 32'h0);
		cmd(SEL_FREEZE, OP_SET_MAX);
		rc(OFS_HPA_STATE, 32'h3, 32'h2);
		barred(28'h0000650);
		end_sim();
	end
endmodule

// File: sim/max_address_command_unit_props.sv
// checker for bus answers, status words and identify copies of the command unit
// assumes single transfers from one master, hready_i tied to hreadyout_o
`timescale 1ns/100ps
module max_address_command_unit_props import hpa_pkg::*; (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// ahb-lite
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hrdata_o,
	input  wire logic        hreadyout_o,
	input  wire logic        hresp_o
);
	logic        dp_rd;
	logic [7:0]  dp_a;
	logic        er_ok;
	logic        er_nz;
	logic        id_ok;
	logic [31:0] id_v;
	wire         ap      = hsel_i & htrans_i[1] & hready_i;
	wire         rd_done = dp_rd & hreadyout_o;
	wire         st_rd   = rd_done && dp_a == OFS_STATUS;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// any write may change error or identify, so remembered reads are dropped then
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			dp_rd <= 1'b0;
			er_ok <= 1'b0;
			id_ok <= 1'b0;
		end else begin
			if (ap) begin
				dp_rd <= !hwrite_i;
				dp_a  <= haddr_i[7:0];
			end else if (hready_i)
				dp_rd <= 1'b0;
			if (ap && hwrite_i) begin
				er_ok <= 1'b0;
				id_ok <= 1'b0;
			end else if (rd_done && dp_a == OFS_ERROR) begin
				er_ok <= 1'b1;
				er_nz <= |hrdata_o[7:0];
			end else if (rd_done && dp_a == OFS_IDENT_60) begin
				id_ok <= 1'b1;
				id_v  <= hrdata_o;
			end
		end
	end
	chk_busy_ready:
		assert property (st_rd |-> !hrdata_o[ST_BSY] && hrdata_o[ST_DRDY])
		else $error("status shows busy or not ready");
	chk_fault_clear:
		assert property (st_rd |-> !hrdata_o[ST_DF]) else $error("status shows fault");
	chk_err_follows:
		assert property (st_rd && er_ok |-> hrdata_o[ST_ERR] == er_nz)
		else $error("status error bit disagrees with error register");
	chk_ident_same:
		assert property (rd_done && dp_a == OFS_IDENT_100 && id_ok |-> hrdata_o == id_v)
		else $error("long identify copy differs");
	chk_state_legal:
		assert property (rd_done && dp_a == OFS_HPA_STATE |-> hrdata_o[1:0] != 2'h3)
		else $error("undefined lock state");
	chk_read_wait:
		assert property (ap && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait is not one cycle");
	chk_write_nowait:
		assert property (ap && hwrite_i |=> hreadyout_o) else $error("write stalled");
	chk_resp_okay:
		assert property (!hresp_o) else $error("response not okay");
endmodule
bind max_address_command_unit max_address_command_unit_props u_props (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
	.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));

// File: sim/task_file_host.sv
// host model: ahb-lite master issuing task-file register accesses
// assumes one slave whose hreadyout is the bus hready
`timescale 1ns/100ps
module task_file_host import hpa_pkg::*; (
	// clock
	input  wire logic        clk_i,
	// bus
	input  wire logic        hready_i,
	input  wire logic [31:0] hrdata_i,
	output logic             hsel_o,
	output logic [31:0]      haddr_o,
	output logic [1:0]       htrans_o,
	output logic             hwrite_o,
	output logic [2:0]       hsize_o,
	output logic [31:0]      hwdata_o
);
	initial begin
		hsel_o   = 1'b0;
		haddr_o  = 32'h0;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hsize_o  = 3'h2;
		hwdata_o = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		hsel_o   <= 1'b1;
		htrans_o <= 2'h2;
		haddr_o  <= {24'h0, a};
		hwrite_o <= w;
		@(posedge clk_i);
		while (!hready_i) @(posedge clk_i);
		hsel_o   <= 1'b0;
		htrans_o <= 2'h0;
		hwdata_o <= d;
		@(posedge clk_i);
		while (!hready_i) @(posedge clk_i);
		q = hrdata_i;
	endtask
	// lba bytes go after the native read, whose answer overwrites them
	task automatic set_max(input logic [27:0] m, input logic v);
		logic [31:0] q;
		// the command pair may only start while the device reports ready
		do xfer(1'b0, OFS_STATUS, 32'h0, q); while (q[ST_DRDY] !== 1'b1);
		xfer(1'b1, OFS_COMMAND, {24'h0, OP_READ_NATIVE}, q);
		xfer(1'b1, OFS_LBA_BYTE_LOW, {24'h0, m[7:0]}, q);
		xfer(1'b1, OFS_LBA_BYTE_MIDDLE, {24'h0, m[15:8]}, q);
		xfer(1'b1, OFS_LBA_BYTE_HIGH, {24'h0, m[23:16]}, q);
		xfer(1'b1, OFS_DEVICE, {24'h0, 4'h4, m[27:24]}, q);
		xfer(1'b1, OFS_SECCNT, {31'h0, v}, q);
		xfer(1'b1, OFS_FEATURES, {24'h0, SEL_PASSWORD}, q);
		xfer(1'b1, OFS_COMMAND, {24'h0, OP_SET_MAX}, q);
	endtask
	task automatic sector();
		logic [31:0] q;
		for (int i = 0; i < SECTOR_WORDS; i++)
			xfer(1'b1, OFS_DATA, 32'(i), q);
	endtask
endmodule
